// ### design/aarc_top.sv
/*
 * Auxiliary converter readback registers and generic digital
 * comparators with event status, mask and interrupt.
 * Assumes a plain register port (read data one cycle after the read
 * strobe), a converter that offers results with a channel code, and a
 * power state machine reset level from the surrounding chip.
 */
// Decided for this implementation: strobed register access.
// Overview of operation
// R1: USB, line, battery results read back, 12-bit
// R2: Die temperature result read back, 12-bit
// R3: Four comparator enables, bits three to zero
// R4: Power sequencer reset clears enables and sources
// R5: Source select bits 15:13 pick channel
// R6: Direction bit 12: below or above threshold
// R7: Threshold bits 11:0, unsigned, reset zero
// R8: Comparator two mirrors comparator one layout
// R9: Enabled comparator checks each new result
// R10: Writes to readback registers are ignored
`timescale 1ns/100ps
module aarc_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	// Converter results
	input  wire logic        conv_valid,
	input  wire logic [2:0]  conv_chan,
	input  wire logic [11:0] conv_data,
	// Power state machine reset, level
	input  wire logic        psm_reset,
	// Interrupt, level
	output logic             irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [3:0]  ena;     // Comparator enables
		logic [15:0] setup1;  // Comparator one setup
		logic [15:0] setup2;  // Comparator two setup
		logic [1:0]  stat;    // Sticky events
		logic [1:0]  mask;    // Event mask
		logic [15:0] rdata;   // Read data
		logic        irq;     // Interrupt
	} aarc_top_t;

	aarc_top_t q;       // Registered state
	aarc_top_t next_q;  // Next state

	logic [1:0] cmp_evt;  // Event pulses of the comparators

	aarc_result_if res ();  // Results to comparators

	// ****************************************
	// Sub-blocks
	// ****************************************
	// Result store; one store feeds both comparators through the interface
	aarc_store u_store (
		.clock      (clock),
		.rstn       (rstn),
		.conv_valid (conv_valid),
		.conv_chan  (conv_chan),
		.conv_data  (conv_data),
		.res        (res.store)
	);

	// Comparator one
	aarc_cmp u_cmp_one (
		.clock  (clock),
		.rstn   (rstn),
		.enable (q.ena[0]),
		.setup  (q.setup1),
		.res    (res.cmp),
		.evt    (cmp_evt[0])
	);

	// Comparator two, same layout as comparator one
	aarc_cmp u_cmp_two (
		.clock  (clock),
		.rstn   (rstn),
		.enable (q.ena[1]),
		.setup  (q.setup2),  // R8
		.res    (res.cmp),
		.evt    (cmp_evt[1])
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Readback word: result in the low bits, upper bits read as zero.
	// Kept in one place so every result register answers the same way.
	function automatic logic [15:0] result_word(input logic [11:0] val);
		result_word = {4'h0, val};
	endfunction

	// Status and mask words: the two event bits in the low bits
	function automatic logic [15:0] event_word(input logic [1:0] bits);
		event_word = {14'h0000, bits};
	endfunction

	// ****************************************
	// Register file and interrupt
	// ****************************************
	// Writes, power sequencer reset, reads and interrupt level.
	// Everything lands at one edge, so a read in the cycle after a write
	// already sees the new value; there is no pipeline to account for.
	always_comb begin
		next_q = q;
		// Events set status; set also wins over a clear below
		next_q.stat = q.stat | cmp_evt;
		if (reg_write) begin
			case (reg_addr)
				// Enable bits; bits two and three are only stored
				aarc_pkg::OFF_ENA: begin
					next_q.ena = reg_wdata[3:0];  // R3
				end
				// Whole setup word of comparator one
				aarc_pkg::OFF_CMP1: begin
					next_q.setup1 = reg_wdata;  // R5 R6 R7
				end
				// Comparator two takes the same layout
				aarc_pkg::OFF_CMP2: begin
					next_q.setup2 = reg_wdata;  // R8
				end
				// Write one to clear; a same-cycle event keeps its bit
				aarc_pkg::OFF_STAT: begin
					next_q.stat = (q.stat & ~reg_wdata[1:0]) | cmp_evt;
				end
				// Mask bits gate the interrupt only, never the status
				aarc_pkg::OFF_MASK: begin
					next_q.mask = reg_wdata[1:0];
				end
				default: begin
					// Readbacks and unmapped offsets keep nothing
					next_q.ena = q.ena;  // R10
				end
			endcase
		end
		// Sequencer reset beats a same-cycle write
		if (psm_reset) begin
			next_q.ena = '0;                                             // R4
			next_q.setup1[aarc_pkg::SRC_HI:aarc_pkg::SRC_LO] = 3'h0;     // R4
			next_q.setup2[aarc_pkg::SRC_HI:aarc_pkg::SRC_LO] = 3'h0;     // R4
		end
		// Read data stand one cycle only, zero otherwise
		next_q.rdata = 16'h0000;
		if (reg_read) begin
			case (reg_addr)
				// Conversion results, read only
				aarc_pkg::OFF_USB: begin
					next_q.rdata = result_word(res.vals[aarc_pkg::CH_USB]);  // R1
				end
				aarc_pkg::OFF_LINE: begin
					next_q.rdata = result_word(res.vals[aarc_pkg::CH_LINE]);  // R1
				end
				aarc_pkg::OFF_BATT: begin
					next_q.rdata = result_word(res.vals[aarc_pkg::CH_BATT]);  // R1
				end
				aarc_pkg::OFF_TEMP: begin
					next_q.rdata = result_word(res.vals[aarc_pkg::CH_TEMP]);  // R2
				end
				// Control and setup words
				aarc_pkg::OFF_ENA: begin
					next_q.rdata = {12'h000, q.ena};
				end
				aarc_pkg::OFF_CMP1: begin
					next_q.rdata = q.setup1;
				end
				aarc_pkg::OFF_CMP2: begin
					next_q.rdata = q.setup2;
				end
				// Event status and mask
				aarc_pkg::OFF_STAT: begin
					next_q.rdata = event_word(q.stat);
				end
				aarc_pkg::OFF_MASK: begin
					next_q.rdata = event_word(q.mask);
				end
				default: begin
					// Unmapped reads answer zero
					next_q.rdata = 16'h0000;
				end
			endcase
		end
		// Level interrupt follows the new status at once
		next_q.irq = |(next_q.stat & next_q.mask);
	end

	// State register; thresholds and directions only see the chip reset,
	// so software need not set them up again after a sequencer reset.
	// Every output below is read straight from this register.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata = q.rdata;
	assign irq       = q.irq;

	// ****************************************
	// Checks
	// ****************************************
	// All checks share the one clock and watch what this block drives,
	// qualified by the register and converter inputs
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	chk_usb_readback: assert property ( // R1
		reg_read && reg_addr == aarc_pkg::OFF_USB |=>
		reg_rdata == {4'h0, $past(res.vals[4])})
		else $error("usb readback wrong");
	chk_temp_readback: assert property ( // R2
		reg_read && reg_addr == aarc_pkg::OFF_TEMP |=>
		reg_rdata == {4'h0, $past(res.vals[7])})
		else $error("temperature readback wrong");
	chk_enable_write: assert property ( // R3
		reg_write && reg_addr == aarc_pkg::OFF_ENA && !psm_reset |=>
		q.ena == $past(reg_wdata[3:0]))
		else $error("enable write not taken");
	chk_psm_clear: assert property ( // R4
		psm_reset |=> q.ena == 4'h0 && q.setup1[15:13] == 3'h0
		&& q.setup2[15:13] == 3'h0)
		else $error("sequencer reset did not clear");
	chk_threshold_hold: assert property ( // R7
		!(reg_write && reg_addr == aarc_pkg::OFF_CMP1) |=> $stable(q.setup1[11:0]))
		else $error("threshold changed without write");
	chk_two_layout: assert property ( // R8
		reg_write && reg_addr == aarc_pkg::OFF_CMP2 && !psm_reset |=>
		q.setup2 == $past(reg_wdata))
		else $error("comparator two setup not taken");
	chk_readonly_ignore: assert property ( // R10
		reg_write && reg_addr == aarc_pkg::OFF_USB && !conv_valid |=> $stable(res.vals))
		else $error("readback changed by write");
	chk_event_sticky: assert property ( // R9
		cmp_evt[0] |=> q.stat[0] && (irq || !q.mask[0]))
		else $error("event not held in status");
	chk_event_two_sticky: assert property ( // R9
		cmp_evt[1] |=> q.stat[1] && (irq || !q.mask[1]))
		else $error("second event not held in status");
	chk_irq_level: assert property (
		$rose(irq) |-> $past(|cmp_evt)
		|| $past(reg_write && reg_addr == aarc_pkg::OFF_MASK))
		else $error("interrupt rose without event or mask write");

	// Further readbacks
	chk_line_readback: assert property ( // R1
		reg_read && reg_addr == aarc_pkg::OFF_LINE |=>
		reg_rdata == {4'h0, $past(res.vals[5])})
		else $error("line readback wrong");
	chk_batt_readback: assert property ( // R1
		reg_read && reg_addr == aarc_pkg::OFF_BATT |=>
		reg_rdata == {4'h0, $past(res.vals[6])})
		else $error("battery readback wrong");
	chk_enable_readback: assert property ( // R3
		reg_read && reg_addr == aarc_pkg::OFF_ENA |=>
		reg_rdata == {12'h000, $past(q.ena)})
		else $error("enable readback wrong");
	chk_setup_readback: assert property ( // R5
		reg_read && reg_addr == aarc_pkg::OFF_CMP1 |=>
		reg_rdata == $past(q.setup1))
		else $error("comparator one readback wrong");
	chk_rdata_idle: assert property (
		!reg_read |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");

	// Setup writes and the sequencer reset
	chk_one_layout: assert property ( // R5
		reg_write && reg_addr == aarc_pkg::OFF_CMP1 && !psm_reset |=>
		q.setup1 == $past(reg_wdata))
		else $error("comparator one setup not taken");
	chk_psm_keeps: assert property ( // R4
		psm_reset && !(reg_write && reg_addr == aarc_pkg::OFF_CMP1) |=>
		q.setup1[12:0] == $past(q.setup1[12:0]))
		else $error("sequencer reset touched threshold or direction");

	// Status and mask
	chk_stat_clear: assert property (
		reg_write && reg_addr == aarc_pkg::OFF_STAT |=>
		(q.stat & $past(reg_wdata[1:0] & ~cmp_evt)) == 2'b00)
		else $error("status bit survived a write-one clear");
	chk_stat_hold: assert property ( // R9
		!(reg_write && reg_addr == aarc_pkg::OFF_STAT) |=>
		(q.stat & $past(q.stat)) == $past(q.stat))
		else $error("status bit lost without a clear");
	chk_mask_write: assert property (
		reg_write && reg_addr == aarc_pkg::OFF_MASK |=> q.mask == $past(reg_wdata[1:0]))
		else $error("mask write not taken");

	cov_event_one: cover property (cmp_evt[0]);
	cov_event_two: cover property (cmp_evt[1]);
	cov_irq_clear: cover property (irq ##1 !irq);
	cov_psm_clear: cover property (psm_reset ##1 !psm_reset);
	cov_masked_event: cover property (cmp_evt[0] && !q.mask[0]);
endmodule

// ### design/aarc_pkg.sv
/*
 * Constants, types and shared functions of the auxiliary converter
 * readback and comparator block.
 * Assumes an 8-bit register address and 16-bit register data.
 */
package aarc_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 8;          // Register address width
	localparam int DATA_W = 16;         // Register data width
	localparam int RES_W  = 12;         // Conversion result width
	localparam int CHAN_N = 8;          // Number of converter channels
	localparam int ENA_W  = 4;          // Comparator enable bits
	localparam int EVT_N  = 2;          // Comparators built here

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_USB  = 8'h9C;  // usb_voltage_result
	localparam logic [7:0] OFF_LINE = 8'h9D;  // line_voltage_result
	localparam logic [7:0] OFF_BATT = 8'h9E;  // battery_voltage_result
	localparam logic [7:0] OFF_TEMP = 8'h9F;  // die_temperature_result
	localparam logic [7:0] OFF_ENA  = 8'hA3;  // comparator_enables
	localparam logic [7:0] OFF_CMP1 = 8'hA4;  // comparator_one_setup
	localparam logic [7:0] OFF_CMP2 = 8'hA5;  // comparator_two_setup
	localparam logic [7:0] OFF_STAT = 8'hB0;  // Event status, write one to clear
	localparam logic [7:0] OFF_MASK = 8'hB1;  // Event mask

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int SRC_HI  = 15;        // Source select top bit
	localparam int SRC_LO  = 13;        // Source select low bit
	localparam int DIR_BIT = 12;        // Direction bit
	localparam int THR_HI  = 11;        // Threshold top bit
	localparam logic [15:0] RST_REG = 16'h0000;  // Reset value of every register

	// ****************************************
	// Channel codes
	// ****************************************
	typedef enum logic [2:0] {
		CH_AUX_INPUT_ONE = 3'h0,
		CH_AUX2 = 3'h1,
		CH_AUX3 = 3'h2,
		CH_AUX_INPUT_FOUR = 3'h3,
		CH_USB  = 3'h4,
		CH_LINE = 3'h5,
		CH_BATT = 3'h6,
		CH_TEMP = 3'h7
	} aarc_chan_t;

	// Strict compare: direction one flags above, zero flags below
	function automatic logic cmp_hit(input logic dir, input logic [11:0] val,
		input logic [11:0] thr);
		cmp_hit = dir ? (val > thr) : (val < thr);
	endfunction

endpackage

// ### design/aarc_result_if.sv
/*
 * Carries the stored conversion results and the update strobe from
 * the result store to the comparators.
 * Assumes all parties share one clock.
 */
`timescale 1ns/100ps
interface aarc_result_if;
	logic [7:0][11:0] vals;     // Latest result of each channel
	logic             upd;      // One-cycle pulse: a result was stored
	logic [2:0]       upd_chan; // Channel of that result
	modport store (output vals, upd, upd_chan);
	modport cmp   (input vals, upd, upd_chan);
endinterface

// ### design/aarc_store.sv
/*
 * Result store: keeps the latest 12-bit result of each of the eight
 * converter channels and pulses an update strobe per stored result.
 * Assumes the converter offers one result per valid cycle.
 */
`timescale 1ns/100ps
module aarc_store (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Converter side
	input  wire logic        conv_valid,
	input  wire logic [2:0]  conv_chan,
	input  wire logic [11:0] conv_data,
	// Result side
	aarc_result_if.store     res
);
	// All state of the store
	typedef struct packed {
		logic [7:0][11:0] vals;
		logic             upd;
		logic [2:0]       chan;
	} aarc_store_t;

	aarc_store_t q;       // Registered state
	aarc_store_t next_q;  // Next state

	// Store a result; strobe is aligned with the new value
	always_comb begin
		next_q = q;
		next_q.upd = conv_valid;
		if (conv_valid) begin
			next_q.vals[conv_chan] = conv_data;
			next_q.chan = conv_chan;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign res.vals     = q.vals;
	assign res.upd      = q.upd;
	assign res.upd_chan = q.chan;

	chk_store_result: assert property (@(posedge clock) disable iff (!rstn) // R1
		conv_valid |=> res.upd && res.vals[$past(conv_chan)] == $past(conv_data))
		else $error("stored result does not match converter data");
endmodule

// ### design/aarc_cmp.sv
/*
 * One digital comparator: checks the selected channel against its
 * threshold each time that channel gets a new result.
 * Assumes setup and enable come from registers of the top module.
 */
`timescale 1ns/100ps
module aarc_cmp (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Setup
	input  wire logic        enable,
	input  wire logic [15:0] setup,
	// Results
	aarc_result_if.cmp       res,
	// Event
	output logic             evt
);
	// All state of the comparator
	typedef struct packed {
		logic evt;
	} aarc_cmp_t;

	aarc_cmp_t q;       // Registered state
	aarc_cmp_t next_q;  // Next state

	logic [2:0]  src;   // Selected channel
	logic        dir;   // Direction
	logic [11:0] thr;   // Threshold

	assign src = setup[aarc_pkg::SRC_HI:aarc_pkg::SRC_LO];  // R5
	assign dir = setup[aarc_pkg::DIR_BIT];                   // R6
	assign thr = setup[aarc_pkg::THR_HI:0];                  // R7

	// Evaluate only when enabled and our channel was just refreshed
	always_comb begin
		next_q = q;
		next_q.evt = enable && res.upd && res.upd_chan == src
			&& aarc_pkg::cmp_hit(dir, res.vals[src], thr);  // R9
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign evt = q.evt;

	chk_event_cause: assert property (@(posedge clock) disable iff (!rstn) // R9
		evt |-> $past(enable && res.upd && res.upd_chan == src))
		else $error("comparator event without enabled update");
	chk_event_direction: assert property (@(posedge clock) disable iff (!rstn) // R6
		$past(enable && res.upd && res.upd_chan == src) |->
		evt == $past(dir ? res.vals[src] > thr : res.vals[src] < thr))
		else $error("comparator event disagrees with direction");
endmodule

// ### bench/testbench.sv
/*
 * Self-checking bench for the converter readback and comparator block.
 * Assumes the design top with plain register and converter ports.
 */
`timescale 1ns/100ps
module testbench;

	// ****************************************
	// Signals
	// ****************************************
	logic        clock;       // 20 MHz clock
	logic        rstn;        // Async reset, low
	logic [7:0]  reg_addr;    // Register offset
	logic [15:0] reg_wdata;   // Write data
	logic        reg_write;   // Write strobe
	logic        reg_read;    // Read strobe
	logic [15:0] reg_rdata;   // Read data
	logic        conv_valid;  // Result strobe
	logic [2:0]  conv_chan;   // Result channel
	logic [11:0] conv_data;   // Result value
	logic        psm_reset;   // Sequencer reset
	logic        irq;         // Interrupt
	int          err_total;   // Mismatches
	int          checked;     // Comparisons
	integer      seed;        // Random seed

	aarc_top dut_u (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_chan(conv_chan),
		.conv_data(conv_data), .psm_reset(psm_reset), .irq(irq));

	// Free-running clock
	always #25 clock = ~clock;

	// ****************************************
	// Tasks
	// ****************************************
	// Compare seen against expected, four-state
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// One converter result
	task automatic conv(input logic [2:0] c, input logic [11:0] d);
		@(posedge clock);
		conv_chan  <= c;
		conv_data  <= d;
		conv_valid <= 1'b1;
		@(posedge clock);
		conv_valid <= 1'b0;
	endtask

	// Strict compare, worked out independently of the design
	function automatic logic want_hit(logic dir, logic [11:0] v, logic [11:0] t);
		if (dir) begin
			return v > t;
		end
		return v < t;
	endfunction

	// Verdict and end of run
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog: 40000 cycles, far beyond the twelve hundred or so cycles the tests need
	initial begin
		#2000000;
		err_total++;
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [15:0] v;           // Read value
		logic [15:0] d;           // Random word
		logic [11:0] thr;         // Threshold
		logic [11:0] val;         // Result value
		logic        hit;         // Expected event
		logic [7:0]  offs [10];   // Offsets for reset check
		offs = '{8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hA3, 8'hA4, 8'hA5, 8'hB0, 8'hB1, 8'hA0};
		clock = 1'b0;
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		conv_valid = 1'b0;
		conv_chan = 3'h0;
		conv_data = 12'h000;
		psm_reset = 1'b0;
		err_total = 0;
		checked = 0;
		seed = 32'hBEB6;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		// All registers clear after reset, unmapped reads zero
		foreach (offs[i]) begin
			rd(offs[i], v);
			chk(v, 16'h0000);
		end
		$display("Test reset values done");
		// Results read back; writes to them have no effect
		for (int c = 4; c < 8; c++) begin
			d = 16'($random(seed));
			conv(3'(c), d[11:0]);
			wr(8'h98 + 8'(c), 16'hFFFF);
			rd(8'h98 + 8'(c), v);
			chk(v, {4'h0, d[11:0]});
		end
		$display("Test readback done");
		// Enable bits and setup words
		d = 16'($random(seed));
		wr(8'hA3, d);
		rd(8'hA3, v);
		chk(v, {12'h000, d[3:0]});
		for (int n = 0; n < 2; n++) begin
			d = 16'($random(seed));
			wr(8'hA4 + 8'(n), d);
			rd(8'hA4 + 8'(n), v);
			chk(v, d);
		end
		$display("Test setup registers done");
		// Every source code, both comparators, random direction, equal value as a corner
		wr(8'hB1, 16'h0003);
		for (int n = 0; n < 2; n++) begin
			for (int s = 0; s < 8; s++) begin
				for (int k = 0; k < 3; k++) begin
					d = 16'($random(seed));
					thr = 12'($random(seed));
					val = (k == 0) ? thr : 12'($random(seed));
					hit = want_hit(d[0], val, thr);
					wr(8'hA4 + 8'(n), {3'(s), d[0], thr});
					wr(8'hA3, 16'(1 << n));
					wr(8'hB0, 16'h0003);
					conv(3'(s), val);
					repeat (3) @(posedge clock);
					rd(8'hB0, v);
					chk(v, 16'(hit) << n);
					chk({15'h0000, irq}, {15'h0000, hit});
					wr(8'hB0, 16'h0003);
					conv(3'(s + 1), val);
					repeat (3) @(posedge clock);
					rd(8'hB0, v);
					chk(v, 16'h0000);
				end
			end
		end
		// Disabled comparator raises nothing
		wr(8'hA4, 16'h9000);
		wr(8'hA3, 16'h0000);
		conv(3'h4, 12'hFFF);
		repeat (3) @(posedge clock);
		rd(8'hB0, v);
		chk(v, 16'h0000);
		$display("Test comparators done");
		// Sequencer reset clears enables and sources only
		wr(8'hA3, 16'h000F);
		wr(8'hA4, 16'hFABC);
		@(posedge clock);
		psm_reset <= 1'b1;
		@(posedge clock);
		psm_reset <= 1'b0;
		rd(8'hA3, v);
		chk(v, 16'h0000);
		rd(8'hA4, v);
		chk(v, 16'h1ABC);
		$display("Test sequencer reset done");
		// Masked event, unmask, then write-one clear
		wr(8'hB1, 16'h0000);
		wr(8'hA4, 16'h9000);
		wr(8'hA3, 16'h0001);
		conv(3'h4, 12'h800);
		repeat (3) @(posedge clock);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		rd(8'hB0, v);
		chk(v, 16'h0001);
		wr(8'hB1, 16'h0001);
		repeat (2) @(posedge clock);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		wr(8'hB0, 16'h0001);
		repeat (2) @(posedge clock);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		rd(8'hB0, v);
		chk(v, 16'h0000);
		$display("Test interrupt done");
		stop_test();
	end

endmodule
